// ---- design/drop_spreader.sv ----
// even spreading of dropped units over one decimation period
// assumes step is a one-cycle pulse from the owner and first is a level that is only valid with step
`timescale 1ns/1ps
module drop_spreader
  import video_front_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic step,
  input wire logic first,
  input wire logic [5:0] drop_count,
  input wire logic [6:0] period,
  output logic drop_hit
);

  logic [6:0] acc;
  logic [6:0] acc_c;
  logic [6:0] count_c;
  logic [6:0] sum;
  logic last_drop;

  // ---------------------------------------------------------------
  // error accumulator
  // ---------------------------------------------------------------
  // counts above the period saturate: every unit is dropped
  always_comb begin
    count_c = ({1'b0, drop_count} > period) ? period : {1'b0, drop_count};
    // a shorter period can leave acc above it for one cycle, until the clear on a cycle without step
    acc_c = (acc >= period) ? 7'h00 : acc;
    sum = acc_c + count_c;
    drop_hit = first ? (count_c != 7'h00) : (sum >= period);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= 7'h00;
    end else if (step) begin
      if (first) begin
        acc <= 7'h00;
      end else if (drop_hit) begin
        acc <= sum - period;
      end else begin
        acc <= sum;
      end
    end else if (acc >= period) begin
      acc <= 7'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_drop <= 1'b0;
    end else if (step) begin
      last_drop <= drop_hit;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_acc_bound: assert property ($stable(period) |-> (acc < period))
    else $error("accumulator reached the period");
  a_no_bunching: assert property (
    (step && !first && last_drop && ({count_c, 1'b0} <= {1'b0, period})) |-> !drop_hit)
    else $error("two drops in a row at a low drop count");

endmodule // drop_spreader

// ---- design/video_front_ctrl.sv ----
// input select, crystal, standard and temporal decimation control
// assumes field_start/field_is_odd come from logic on aclk and that
// line_count_indicator is an asynchronous level from the decoder
//
// How it works
// - mux field 00 routes analog input three to the video output.
// - crystal field: 01 crystal zero, 10 crystal one, 11 automatic, 00 reserved.
// - standard field 000 detects the standard from the line count indicator.
// - standard codes 001 to 110 force the corresponding input standard.
// - code 111 forces pal n-combination on the enhanced variant only.
// - decimation register resets to zero, nothing dropped after reset.
// - decimation bit 7 selects frame (0) or field (1) dropping.
// - decimation bit 6 selects parity of first dropped field, 0 odd.
// - drop count gives units dropped per 60 (ntsc) or 50 otherwise.
// - drop count zero disables decimation, everything passes.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module video_front_ctrl
  import video_front_pkg::*;
#(
  parameter bit enhanced_variant = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_count_indicator,
  input wire logic field_start,
  input wire logic field_is_odd,
  output logic [3:0] selected_video_out,
  output logic crystal_zero,
  output logic crystal_one,
  output logic [2:0] video_standard,
  output logic field_pass,
  output logic field_drop
);

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane;
  logic do_write;
  logic [7:0] input_format_control;
  logic [7:0] temporal_decimation_control;
  logic decim_written;
  logic [7:0] status_word;

  function automatic logic is_mapped(input logic [11:0] addr);
    if (addr == STATUS_OFFSET) begin
      return 1'b1;
    end else if (addr == FORMAT_OFFSET) begin
      return 1'b1;
    end else if (addr == DECIM_OFFSET) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= {s_axi_awaddr[11:2], 2'b00};
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // reserved bit 7 of the format register always stores zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_format_control <= FORMAT_RESET;
    end else if (do_write && w_lane && (aw_addr == FORMAT_OFFSET)) begin
      input_format_control <= {1'b0, w_byte[FMT_RSVD_BIT-1:0]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temporal_decimation_control <= DECIM_RESET;
      decim_written <= 1'b0;
    end else if (do_write && w_lane && (aw_addr == DECIM_OFFSET)) begin
      temporal_decimation_control <= w_byte;
      decim_written <= 1'b1;
    end else begin
      decim_written <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr[11:2] == STATUS_OFFSET[11:2]) begin
        s_axi_rdata <= {24'h00_0000, status_word};
      end else if (s_axi_araddr[11:2] == FORMAT_OFFSET[11:2]) begin
        s_axi_rdata <= {24'h00_0000, input_format_control};
      end else if (s_axi_araddr[11:2] == DECIM_OFFSET[11:2]) begin
        s_axi_rdata <= {24'h00_0000, temporal_decimation_control};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // line count indicator synchroniser
  // ---------------------------------------------------------------
  logic lci_s1;
  logic lci_s2;
  logic lci_s3;
  logic lci;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lci_s1 <= 1'b0;
      lci_s2 <= 1'b0;
      lci_s3 <= 1'b0;
      lci <= 1'b0;
    end else begin
      lci_s1 <= line_count_indicator;
      lci_s2 <= lci_s1;
      lci_s3 <= lci_s2;
      if (lci_s2 == lci_s3) begin
        lci <= lci_s3;
      end
    end
  end

  // ---------------------------------------------------------------
  // input, crystal and standard selection
  // ---------------------------------------------------------------
  logic [1:0] mux_field;
  logic [1:0] xt_field;
  logic [2:0] std_field;
  logic [2:0] detected;
  logic [2:0] next_standard;
  logic [3:0] next_select;
  logic next_xt0;
  logic next_xt1;

  assign mux_field = input_format_control[MUX_LSB +: 2];
  assign xt_field = input_format_control[XT_LSB +: 2];
  assign std_field = input_format_control[STD_LSB +: 3];
  // a long line count means a 625-line standard
  assign detected = lci ? STD_PAL_BDGHI : STD_NTSC_M;

  always_comb begin
    case (mux_field)
      MUX_INPUT_THREE: next_select = SEL_THREE;
      MUX_INPUT_TWO: next_select = SEL_TWO;
      MUX_INPUT_ZERO: next_select = SEL_ZERO;
      default: next_select = SEL_ONE;
    endcase
  end

  // reserved 111 on the base variant falls back to detection
  always_comb begin
    case (std_field)
      STD_AUTO: next_standard = detected;
      STD_PAL_NC: next_standard = enhanced_variant ? STD_PAL_NC : detected;
      default: next_standard = std_field;
    endcase
  end

  always_comb begin
    case (xt_field)
      XT_ZERO: begin
        next_xt0 = 1'b1;
        next_xt1 = 1'b0;
      end
      XT_ONE: begin
        next_xt0 = 1'b0;
        next_xt1 = 1'b1;
      end
      XT_AUTO: begin
        next_xt0 = is_ntsc(next_standard);
        next_xt1 = !is_ntsc(next_standard);
      end
      default: begin
        next_xt0 = 1'b1;
        next_xt1 = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      selected_video_out <= SEL_THREE;
      video_standard <= STD_NTSC_M;
      crystal_zero <= 1'b1;
      crystal_one <= 1'b0;
    end else begin
      selected_video_out <= next_select;
      video_standard <= next_standard;
      crystal_zero <= next_xt0;
      crystal_one <= next_xt1;
    end
  end

  // ---------------------------------------------------------------
  // temporal decimation
  // ---------------------------------------------------------------
  dec_state_t state;
  dec_state_t next_state;
  logic by_field;
  logic even_first;
  logic [5:0] drop_count;
  logic [6:0] period;
  logic [6:0] last_period;
  logic lead_field;
  logic step;
  logic first;
  logic drop_hit;
  logic frame_drop;
  logic next_drop;

  assign by_field = temporal_decimation_control[DECIMATE_BY_FIELD_BIT];
  assign even_first = temporal_decimation_control[PARITY_BIT];
  assign drop_count = temporal_decimation_control[RATE_LSB +: 6];
  assign period = is_ntsc(video_standard) ? PERIOD_NTSC : PERIOD_PAL;
  // a field of the chosen parity opens each frame and the first dropped unit
  assign lead_field = (field_is_odd != even_first);

  // any decimation write with a nonzero count, or a period change, realigns the period
  always_comb begin
    next_state = state;
    case (state)
      DEC_OFF: if (drop_count != 6'h00) next_state = DEC_ALIGN;
      DEC_ALIGN: if (field_start && lead_field) next_state = DEC_RUN;
      DEC_RUN: next_state = DEC_RUN;
      default: next_state = DEC_OFF;
    endcase
    if (drop_count == 6'h00) begin
      next_state = DEC_OFF;
    end else if (decim_written || (period != last_period)) begin
      next_state = DEC_ALIGN;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= DEC_OFF;
      last_period <= PERIOD_NTSC;
    end else begin
      state <= next_state;
      last_period <= period;
    end
  end

  // frame mode advances once per frame, on its leading field
  always_comb begin
    first = (state == DEC_ALIGN) && lead_field;
    step = 1'b0;
    next_drop = 1'b0;
    if (field_start && (drop_count != 6'h00)) begin
      case (state)
        DEC_ALIGN: begin
          step = first;
          next_drop = first && drop_hit;
        end
        DEC_RUN: begin
          if (by_field || lead_field) begin
            step = 1'b1;
            next_drop = drop_hit;
          end else begin
            next_drop = frame_drop;
          end
        end
        default: next_drop = 1'b0;
      endcase
    end
  end

  drop_spreader spreader (
    .aclk(aclk),
    .aresetn(aresetn),
    .step(step),
    .first(first),
    .drop_count(drop_count),
    .period(period),
    .drop_hit(drop_hit)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_drop <= 1'b0;
    end else if (step) begin
      frame_drop <= drop_hit;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      field_pass <= 1'b0;
      field_drop <= 1'b0;
    end else begin
      field_pass <= field_start && !next_drop;
      field_drop <= field_start && next_drop;
    end
  end

  assign status_word = {state == DEC_RUN, lci, crystal_one, crystal_zero,
                        1'b0, video_standard};

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_mux_three: assert property (
    (mux_field == MUX_INPUT_THREE) |=> (selected_video_out == SEL_THREE))
    else $error("input three not routed for mux code 00");
  a_crystal_pick: assert property (
    (xt_field == XT_ONE) |=> (crystal_one && !crystal_zero))
    else $error("crystal one not selected for code 10");
  a_auto_detect: assert property (
    (std_field == STD_AUTO) && lci && $past(lci) |=> (video_standard == STD_PAL_BDGHI))
    else $error("long line count not detected as pal");
  a_forced_std: assert property (
    (std_field != STD_AUTO) && (std_field != STD_PAL_NC)
      |=> (video_standard == $past(std_field)))
    else $error("forced standard not applied");
  a_pal_nc: assert property (
    (std_field == STD_PAL_NC) |=> (video_standard == (enhanced_variant ? STD_PAL_NC
      : $past(detected))))
    else $error("code 111 handled wrongly for this variant");
  a_decim_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> (temporal_decimation_control == DECIM_RESET) && !field_drop)
    else $error("decimation not cleared by reset");
  a_zero_pass: assert property (
    field_start && (drop_count == 6'h00) |=> field_pass && !field_drop)
    else $error("field dropped with decimation disabled");
  a_first_parity: assert property (
    field_start && (state == DEC_ALIGN) && !decim_written && !lead_field
      |=> field_pass)
    else $error("field of wrong parity dropped first");
  a_frame_pair: assert property (
    field_start && (state == DEC_RUN) && !by_field && !lead_field && (drop_count != 6'h00)
      |=> (field_drop == $past(frame_drop)))
    else $error("second field of a frame split from its first");

endmodule // video_front_ctrl

// ---- design/video_front_pkg.sv ----
// constants, register map and types of the video input front end
// assumes a single 40 mhz capture clock and an axi4-lite register port
package video_front_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] STATUS_OFFSET = 12'h000;
  localparam logic [11:0] FORMAT_OFFSET = 12'h004;
  localparam logic [11:0] DECIM_OFFSET = 12'h008;
  localparam logic [7:0] FORMAT_RESET = 8'h18;
  localparam logic [7:0] DECIM_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FMT_RSVD_BIT = 7;
  localparam int MUX_LSB = 5;
  localparam int XT_LSB = 3;
  localparam int STD_LSB = 0;
  localparam int DECIMATE_BY_FIELD_BIT = 7;
  localparam int PARITY_BIT = 6;
  localparam int RATE_LSB = 0;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] MUX_INPUT_THREE = 2'h0;
  localparam logic [1:0] MUX_INPUT_TWO = 2'h1;
  localparam logic [1:0] MUX_INPUT_ZERO = 2'h2;
  localparam logic [3:0] SEL_THREE = 4'h8;
  localparam logic [3:0] SEL_TWO = 4'h4;
  localparam logic [3:0] SEL_ONE = 4'h2;
  localparam logic [3:0] SEL_ZERO = 4'h1;
  localparam logic [1:0] XT_RESERVED = 2'h0;
  localparam logic [1:0] XT_ZERO = 2'h1;
  localparam logic [1:0] XT_ONE = 2'h2;
  localparam logic [1:0] XT_AUTO = 2'h3;
  localparam logic [2:0] STD_AUTO = 3'h0;
  localparam logic [2:0] STD_NTSC_M = 3'h1;
  localparam logic [2:0] STD_NTSC_NOPED = 3'h2;
  localparam logic [2:0] STD_PAL_BDGHI = 3'h3;
  localparam logic [2:0] STD_PAL_M = 3'h4;
  localparam logic [2:0] STD_PAL_N = 3'h5;
  localparam logic [2:0] STD_SECAM = 3'h6;
  localparam logic [2:0] STD_PAL_NC = 3'h7;
  localparam logic [6:0] PERIOD_NTSC = 7'h3c;
  localparam logic [6:0] PERIOD_PAL = 7'h32;

  typedef enum logic [2:0] {
    DEC_OFF = 3'b001,
    DEC_ALIGN = 3'b010,
    DEC_RUN = 3'b100
  } dec_state_t;

  // ntsc standards count units out of 60, all others out of 50
  function automatic logic is_ntsc(input logic [2:0] std);
    return (std == STD_NTSC_M) || (std == STD_NTSC_NOPED);
  endfunction

endpackage

// ---- dv/field_source.sv ----
// field stream model: paced fields of alternating parity
// assumes run and pal_source come from the bench on aclk
`timescale 1ns/1ps
module field_source (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic pal_source,
  output logic field_start,
  output logic field_is_odd,
  output logic line_count_indicator
);
  logic [1:0] gap;
  // ----
  // pacing
  // ----
  // a field every 4 cycles, short but keeps pulses apart
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      gap <= 2'h0;
      field_start <= 1'b0;
      field_is_odd <= 1'b1;
    end else begin
      gap <= gap + 2'h1;
      field_start <= (gap == 2'h3);
      if (field_start) begin
        field_is_odd <= !field_is_odd;
      end
    end
  end
  // ----
  // line count level
  // ----
  always_ff @(posedge aclk) begin
    line_count_indicator <= pal_source;
  end
endmodule // field_source

// ---- dv/video_front_ctrl_test.sv ----
// self-checking bench for video_front_ctrl
// assumes field_source feeds fields; the bench is the axi master
`timescale 1ns/1ps
module video_front_ctrl_test
  import video_front_pkg::*;
;
  logic aclk, aresetn, run, pal, fs, fodd, lci, st_q, par_q, seen, first_odd;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, sel;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, x0, x1, fpass, fdrop;
  logic [2:0] vstd;
  int err_total, n_tests, n_res, n_drop, run_len, max_run;
  typedef struct packed {
    logic [7:0] fmt;
    logic pal;
    logic [3:0] sel;
    logic [1:0] xt;
    logic [2:0] std;
  } row_t;
  // ----
  // format rows: value, line count, mux, crystals, standard
  // ----
  row_t rows [14] = '{
    '{8'h01, 1'b0, 4'h8, 2'b10, 3'h1},
    '{8'h0b, 1'b0, 4'h8, 2'b10, 3'h3},
    '{8'h16, 1'b0, 4'h8, 2'b01, 3'h6},
    '{8'h18, 1'b0, 4'h8, 2'b10, 3'h1},
    '{8'h18, 1'b1, 4'h8, 2'b01, 3'h3},
    '{8'h19, 1'b1, 4'h8, 2'b10, 3'h1},
    '{8'h1a, 1'b0, 4'h8, 2'b10, 3'h2},
    '{8'h1b, 1'b0, 4'h8, 2'b01, 3'h3},
    '{8'h1c, 1'b0, 4'h8, 2'b01, 3'h4},
    '{8'h1d, 1'b0, 4'h8, 2'b01, 3'h5},
    '{8'h1f, 1'b0, 4'h8, 2'b01, 3'h7},
    '{8'h21, 1'b0, 4'h4, 2'b10, 3'h1},
    '{8'h41, 1'b0, 4'h1, 2'b10, 3'h1},
    '{8'h61, 1'b0, 4'h2, 2'b10, 3'h1}
  };

  video_front_ctrl #(.enhanced_variant(1'b1)) video_front_ctrl_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_count_indicator(lci), .field_start(fs), .field_is_odd(fodd),
    .selected_video_out(sel), .crystal_zero(x0), .crystal_one(x1),
    .video_standard(vstd), .field_pass(fpass), .field_drop(fdrop)
  );
  field_source field_source_i (
    .aclk(aclk), .aresetn(aresetn), .run(run), .pal_source(pal),
    .field_start(fs), .field_is_odd(fodd), .line_count_indicator(lci)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // no fixed latency assumed: wait for the answer under a bound
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    bit ad, wd;
    int t;
    ad = 0; wd = 0; t = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (t < 100) begin
      @(posedge aclk);
      t++;
      if (ad && wd && bvalid) begin
        chk("bresp", 32'(er), 32'(bresp));
        bready <= 1'b0;
        t = 200;
      end
      if (!ad && awready) begin ad = 1; awvalid <= 1'b0; end
      if (!wd && wready) begin wd = 1; wvalid <= 1'b0; end
    end
    if (t != 200) chk("bvalid", 1, 0);
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] e,
                        input logic [1:0] er, input string nm);
    bit ad;
    int t;
    ad = 0; t = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (t < 100) begin
      @(posedge aclk);
      t++;
      if (ad && rvalid) begin
        chk(nm, e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
        rready <= 1'b0;
        t = 200;
      end
      if (!ad && arready) begin ad = 1; arvalid <= 1'b0; end
    end
    if (t != 200) chk("rvalid", 1, 0);
  endtask
  task automatic wait_res(input int n);
    int t0, t;
    t0 = n_res; t = 0;
    while (n_res < t0 + n && t < 2000) begin @(posedge aclk); t++; end
    if (t >= 2000) chk("results", 1, 0);
  endtask
  // count 0 first so no old decision leaks into the window
  task automatic dec_run(input logic [7:0] fmt, dec, input int win, nd, mr,
                         input logic odd);
    int d0;
    axi_wr(FORMAT_OFFSET, 32'(fmt), 4'hf, RESP_OKAY);
    axi_wr(DECIM_OFFSET, 32'h0, 4'hf, RESP_OKAY);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    seen = 0; max_run = 0; run_len = 0;
    axi_wr(DECIM_OFFSET, 32'(dec), 4'hf, RESP_OKAY);
    wait_res(8);
    d0 = n_drop;
    wait_res(win);
    chk("drops", 32'(nd), 32'(n_drop - d0));
    chk("max_run", 32'(mr), 32'(max_run));
    if (nd > 0) chk("first_odd", 32'(odd), 32'(first_odd));
  endtask
  // ----
  // field monitor: one decision a cycle after each field
  // ----
  always @(posedge aclk) begin
    if (aresetn && st_q) begin
      n_res++;
      chk("one_result", 1, 32'(fpass ^ fdrop));
      if (fdrop === 1'b1) begin
        n_drop++;
        run_len++;
        if (run_len > max_run) max_run = run_len;
        if (!seen) begin seen = 1; first_odd = par_q; end
      end else run_len = 0;
    end
    st_q <= fs;
    if (fs) par_q <= fodd;
  end
  // ----
  // main sequence
  // ----
  initial begin
    aresetn = 0; run = 0; pal = 0; st_q = 0; par_q = 0; seen = 0; first_odd = 0;
    awaddr = 0; awvalid = 0; wdata = 0; wstrb = 0; wvalid = 0; bready = 0;
    araddr = 0; arvalid = 0; rready = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    run <= 1'b1;
    @(posedge aclk);
    chk("sel", 32'h8, 32'(sel));
    chk("xtal", 32'h2, 32'({x0, x1}));
    axi_rd(FORMAT_OFFSET, 32'h18, RESP_OKAY, "format");
    axi_rd(DECIM_OFFSET, 32'h0, RESP_OKAY, "decim");
    foreach (rows[i]) begin
      pal <= rows[i].pal;
      axi_wr(FORMAT_OFFSET, 32'(rows[i].fmt), 4'h1, RESP_OKAY);
      axi_rd(FORMAT_OFFSET, 32'(rows[i].fmt), RESP_OKAY, "format");
      repeat (8) @(posedge aclk);
      chk("sel", 32'(rows[i].sel), 32'(sel));
      chk("xtal", 32'(rows[i].xt), 32'({x0, x1}));
      chk("std", 32'(rows[i].std), 32'(vstd));
    end
    dec_run(8'h09, 8'h8a, 60, 10, 1, 1'b1);
    dec_run(8'h09, 8'hca, 60, 10, 1, 1'b0);
    dec_run(8'h0b, 8'h8a, 50, 10, 1, 1'b1);
    dec_run(8'h0b, 8'h05, 100, 10, 2, 1'b1);
    dec_run(8'h0b, 8'h4a, 100, 20, 2, 1'b0);
    dec_run(8'h0b, 8'hc0, 50, 0, 0, 1'b0);
    axi_wr(12'h0f0, 32'h55, 4'hf, RESP_SLVERR);
    axi_rd(12'h0f0, 32'h0, RESP_SLVERR, "unmapped");
    axi_wr(DECIM_OFFSET, 32'h3f, 4'h0, RESP_OKAY);
    axi_rd(DECIM_OFFSET, 32'hc0, RESP_OKAY, "decim");
    axi_wr(FORMAT_OFFSET, 32'hff, 4'h1, RESP_OKAY);
    axi_rd(FORMAT_OFFSET, 32'h7f, RESP_OKAY, "format");
    axi_wr(STATUS_OFFSET, 32'hff, 4'hf, RESP_OKAY);
    axi_rd(STATUS_OFFSET, 32'h27, RESP_OKAY, "status");
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(DECIM_OFFSET, 32'h0, RESP_OKAY, "decim");
    axi_rd(FORMAT_OFFSET, 32'h18, RESP_OKAY, "format");
    axi_rd(STATUS_OFFSET, 32'h11, RESP_OKAY, "status");
    end_of_test();
  end
  // the run needs well under 10000 cycles
  initial begin
    repeat (40000) @(posedge aclk);
    err_total++;
    end_of_test();
  end
endmodule // video_front_ctrl_test
